// ---- design/lcs_ctrl_sym.sv ----
/*
 Control symbol command handling: receive check and decode of secondary functions,
 reset lockout, input-status answer and CRC sealing of outgoing symbols.
 Assumes symbol input, port state and transmit sink all run on clock.
*/
`timescale 1ns/100ps
module lcs_ctrl_sym
#(
    parameter int ACK_W = 5,
    parameter int RST_CNT = lcs_pkg::RST_CMD_COUNT
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire lcs_pkg::lcs_sym_t rx_sym,
    input wire logic rx_pkt_data,
    input wire logic retry_req,
    input wire logic port_err,
    input wire logic [4:0] port_status,
    input wire logic [ACK_W-1:0] exp_ack_tag,
    output logic pkt_accept,
    output logic pkt_abort,
    output logic restart_err,
    output logic dev_reset,
    output logic mcast_event,
    output logic eop_seen,
    output logic crc_err,
    output logic flush_req,
    input wire logic flush_done,
    input wire logic usr_valid,
    input wire lcs_pkg::lcs_sym_t usr_sym,
    output logic usr_ready,
    output logic usr_reject,
    output logic tx_valid,
    output lcs_pkg::lcs_sym_t tx_sym,
    input wire logic tx_ready
);
    import lcs_pkg::*;

    // ==========================================================
    // Parameter checks
    if (ACK_W < 1 || ACK_W > 5)
    begin : g_bad_ack
        $error("ACK_W must be 1 to 5");
    end
    if (RST_CNT < 2 || RST_CNT > 16)
    begin : g_bad_cnt
        $error("RST_CNT must be 2 to 16");
    end

    localparam int CW = $clog2(RST_CNT);
    localparam logic [CW-1:0] CNT_LAST = CW'(RST_CNT - 1);

    // ==========================================================
    // CRC
    // Single stage, preset and trailing zero folded in
    function automatic logic [4:0] crc5(input logic [0:18] d);
        logic [4:0] c;
        c[4] = d[0]^d[2]^d[3]^d[4]^d[9]^d[11]^d[14]^d[15]^d[17]^d[18];
        c[3] = d[1]^d[2]^d[3]^d[8]^d[10]^d[13]^d[14]^d[16]^d[17]^~d[18];
        c[2] = d[1]^d[3]^d[4]^d[7]^d[11]^d[12]^d[13]^d[14]^d[16]^~d[18];
        c[1] = d[0]^d[2]^d[3]^d[6]^d[10]^d[11]^d[12]^d[13]^d[15]^d[17]^~d[18];
        c[0] = d[0]^d[1]^d[3]^d[4]^d[5]^d[10]^d[12]^d[15]^d[16]^d[18];
        // c0 lands in bit 19, c4 in bit 23
        return {c[0], c[1], c[2], c[3], c[4]};
    endfunction

    // Append check bits over symbol bits 0 to 18
    function automatic lcs_sym_t seal(input lcs_sym_t s);
        lcs_sym_t r;
        r = s;
        r.crc = crc5(s[23:5]);
        return r;
    endfunction

    // ==========================================================
    // Receive decode
    logic crc_ok;
    logic rx_ok;
    logic is_rfr;
    logic is_lreq;
    logic is_rst;
    logic is_ist;
    logic is_mcast;
    logic status_only;
    logic rst_fire;
    logic [CW-1:0] rst_cnt_ff;
    lcs_rsp_t rsp_ff;

    // Checked symbol and its secondary function
    assign crc_ok = (crc5(rx_sym[23:5]) == rx_sym.crc);
    assign rx_ok = rx_valid & crc_ok;
    assign is_rfr = rx_sym.secondary_symbol_type == ST1_RETRY;
    assign is_lreq = rx_sym.secondary_symbol_type == ST1_LREQ;
    assign is_mcast = rx_sym.secondary_symbol_type == ST1_MCAST;
    assign is_rst = is_lreq & (rx_sym.cmd == CMD_RST_DEV);
    assign is_ist = is_lreq & (rx_sym.cmd == CMD_IN_STAT);
    assign status_only = (rx_sym.primary_symbol_type == ST0_STATUS) &
        (rx_sym.secondary_symbol_type == ST1_NOP);
    // Last reset-device of an unbroken run
    assign rst_fire = rx_ok & is_rst & ~rx_pkt_data & (rst_cnt_ff == CNT_LAST);

    // ==========================================================
    // Reset lockout counter
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rst_cnt_ff <= '0;
        end
        else if (rx_pkt_data || rst_fire)
        begin
            rst_cnt_ff <= '0;
        end
        else if (rx_ok)
        begin
            if (is_rst)
            begin
                rst_cnt_ff <= rst_cnt_ff + 1'b1;
            end
            else if (!status_only)
            begin
                rst_cnt_ff <= '0;
            end
        end
    end

    // ==========================================================
    // Event pulses to the port
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pkt_abort <= 1'b0;
            restart_err <= 1'b0;
            dev_reset <= 1'b0;
            mcast_event <= 1'b0;
            eop_seen <= 1'b0;
            crc_err <= 1'b0;
        end
        else
        begin
            pkt_abort <= rx_ok & (is_rfr | is_lreq);
            restart_err <= rx_ok & is_ist & port_err;
            dev_reset <= rst_fire;
            mcast_event <= rx_ok & is_mcast;
            eop_seen <= rx_ok & (rx_sym.secondary_symbol_type == ST1_EOP);
            crc_err <= rx_valid & ~crc_ok;
        end
    end

    // ==========================================================
    // Retry-stopped input state; device reset beats a retry, a retry beats a restart
    logic retry_stop_ff;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            retry_stop_ff <= 1'b0;
        end
        else if (rst_fire)
        begin
            retry_stop_ff <= 1'b0;
        end
        else if (retry_req)
        begin
            retry_stop_ff <= 1'b1;
        end
        else if (rx_ok && is_rfr)
        begin
            retry_stop_ff <= 1'b0;
        end
    end

    assign pkt_accept = ~retry_stop_ff;

    // ==========================================================
    // Input-status answer sequencer
    logic [4:0] cap_ack_ff;
    logic [4:0] cap_stat_ff;
    logic slot_free;
    logic rsp_go;
    logic ist_take;

    assign slot_free = ~tx_valid | tx_ready;
    assign rsp_go = (rsp_ff == RSP_SEND) & slot_free;
    assign ist_take = rx_ok & is_ist & (rsp_ff == RSP_IDLE);

    // Flush first, then one link-response; reset-device never enters
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_ff <= RSP_IDLE;
            flush_req <= 1'b0;
        end
        else if (rst_fire)
        begin
            rsp_ff <= RSP_IDLE;
            flush_req <= 1'b0;
        end
        else
        begin
            case (rsp_ff)
                RSP_IDLE:
                begin
                    if (ist_take)
                    begin
                        rsp_ff <= RSP_FLUSH;
                        flush_req <= 1'b1;
                    end
                end
                RSP_FLUSH:
                begin
                    if (flush_done)
                    begin
                        rsp_ff <= RSP_SEND;
                        flush_req <= 1'b0;
                    end
                end
                RSP_SEND:
                begin
                    if (slot_free)
                    begin
                        rsp_ff <= RSP_IDLE;
                    end
                end
                default:
                begin
                    rsp_ff <= RSP_IDLE;
                    flush_req <= 1'b0;
                end
            endcase
        end
    end

    // Port state as seen when the request arrived
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cap_ack_ff <= RST_ACK;
            cap_stat_ff <= RST_STAT;
        end
        else if (ist_take)
        begin
            cap_ack_ff <= 5'(exp_ack_tag);
            cap_stat_ff <= port_status;
        end
    end

    // ==========================================================
    // Transmit slot
    logic usr_bad;
    logic usr_take;
    lcs_sym_t rsp_sym;

    assign usr_ready = slot_free & (rsp_ff != RSP_SEND);
    assign usr_take = usr_valid & usr_ready;
    // Reserved link-request commands never leave the port
    assign usr_bad = (usr_sym.secondary_symbol_type == ST1_LREQ) &
        (usr_sym.cmd != CMD_RST_DEV) & (usr_sym.cmd != CMD_IN_STAT);
    assign rsp_sym = '{primary_symbol_type: ST0_LRESP, param0: cap_ack_ff,
        param1: cap_stat_ff, secondary_symbol_type: ST1_NOP, cmd: CMD_NONE, crc: 5'h00};

    // Response first, then user symbols, all sealed
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_valid <= 1'b0;
            tx_sym <= '0;
            usr_reject <= 1'b0;
        end
        else
        begin
            usr_reject <= usr_take & usr_bad;
            if (rsp_go)
            begin
                tx_valid <= 1'b1;
                tx_sym <= seal(rsp_sym);
            end
            else if (usr_take && !usr_bad)
            begin
                tx_valid <= 1'b1;
                tx_sym <= seal(usr_sym);
            end
            else if (tx_ready)
            begin
                tx_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    chk_tx_crc_sealed: assert property (tx_valid |-> crc5(tx_sym[23:5]) == tx_sym.crc)
        else $error("outgoing symbol carries wrong CRC");
    chk_bad_crc_drop: assert property (rx_valid && !crc_ok |=>
        !pkt_abort && !dev_reset && !mcast_event && !restart_err && crc_err)
        else $error("symbol with bad CRC was acted on");
    chk_abort_on_cmd: assert property (rx_ok && (is_rfr || is_lreq) |=> pkt_abort)
        else $error("restart or link-request did not abort packet");
    chk_retry_hold: assert property (retry_req && !rst_fire |=> !pkt_accept)
        else $error("packets accepted while retry-stopped");
    chk_retry_release: assert property ($rose(pkt_accept) |-> pkt_abort || dev_reset)
        else $error("packet acceptance resumed without restart");
    chk_err_restart: assert property (rx_ok && is_ist && port_err |=> restart_err)
        else $error("input-status under error not a restart");
    chk_reset_lockout: assert property (dev_reset |-> $past(rx_ok && is_rst) &&
        $past(rst_cnt_ff) == CNT_LAST)
        else $error("reset without full run of reset-device");
    chk_reset_wipe: assert property (rst_fire |=> rsp_ff == RSP_IDLE && pkt_accept
        && rst_cnt_ff == 0 && !flush_req)
        else $error("reset-device left state behind");
    chk_no_rst_answer: assert property (rx_ok && is_rst && rsp_ff == RSP_IDLE |=>
        rsp_ff == RSP_IDLE)
        else $error("reset-device started a response");
    chk_flush_before: assert property (ist_take && !rst_fire |=> flush_req && rsp_ff == RSP_FLUSH)
        else $error("input-status did not start a flush");
    // Send state is only entered on a completed flush
    chk_send_after_flush: assert property ($rose(rsp_ff == RSP_SEND) |-> $past(flush_done && flush_req))
        else $error("response began before flush");
    chk_rsp_state: assert property (rsp_go |=> tx_valid &&
        tx_sym.primary_symbol_type == ST0_LRESP && tx_sym.param0 == cap_ack_ff &&
        tx_sym.param1 == cap_stat_ff)
        else $error("link-response wrong or missing");
    chk_cnt_clear: assert property (rx_pkt_data |=> rst_cnt_ff == 0)
        else $error("packet did not clear reset counter");
    chk_mcast_pass: assert property (rx_ok && is_mcast |=> mcast_event)
        else $error("multicast event not passed on");
    chk_reserved_cmd: assert property (usr_take && usr_bad |=> usr_reject &&
        !(tx_valid && $changed(tx_sym) && tx_sym.secondary_symbol_type == ST1_LREQ))
        else $error("reserved link-request command sent");

endmodule

// ---- inc/lcs_pkg.sv ----
/*
 Shared types and constants for the link control symbol command and CRC block.
 Assumes a 24-bit control symbol whose bit 0 is the most significant bit of the word.
*/
package lcs_pkg;

    // ==========================================================
    // Symbol field encodings
    localparam logic [2:0] ST1_EOP = 3'h2;
    localparam logic [2:0] ST1_RETRY = 3'h3;
    localparam logic [2:0] ST1_LREQ = 3'h4;
    localparam logic [2:0] ST1_MCAST = 3'h5;
    localparam logic [2:0] ST1_NOP = 3'h7;
    localparam logic [2:0] CMD_RST_DEV = 3'h3;
    localparam logic [2:0] CMD_IN_STAT = 3'h4;
    localparam logic [2:0] CMD_NONE = 3'h0;
    // Primary types used here; values are a free choice of this block
    localparam logic [2:0] ST0_STATUS = 3'h4;
    localparam logic [2:0] ST0_LRESP = 3'h6;
    localparam logic [4:0] PST_OK = 5'h10;
    localparam int RST_CMD_COUNT = 4;

    // ==========================================================
    // Reset values
    localparam logic [4:0] RST_ACK = 5'h00;
    localparam logic [4:0] RST_STAT = 5'h00;

    // ==========================================================
    // Types
    typedef struct packed
    {
        logic [2:0] primary_symbol_type;
        logic [4:0] param0;
        logic [4:0] param1;
        logic [2:0] secondary_symbol_type;
        logic [2:0] cmd;
        logic [4:0] crc;
    } lcs_sym_t;

    typedef enum logic [1:0]
    {
        RSP_IDLE = 2'b00,
        RSP_FLUSH = 2'b01,
        RSP_SEND = 2'b10
    } lcs_rsp_t;

endpackage

// ---- sim/lcs_ctrl_sym_tb_top.sv ----
/*
 Self-checking bench for lcs_ctrl_sym with the peer model on the link side.
 Assumes package defaults: five-bit ack tag, lockout of four commands.
*/
`timescale 1ns/100ps
module lcs_ctrl_sym_tb_top;
    import lcs_pkg::*;
    // ==========================================================
    // Signals and tables
    localparam logic [2:0] ST1S [4] = '{ST1_EOP, ST1_RETRY, ST1_MCAST, ST1_NOP};
    localparam logic [5:0] EXPS [4] = '{6'h02, 6'h20, 6'h04, 6'h00};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic rx_pkt_data = 1'b0, retry_req = 1'b0, port_err = 1'b0, usr_valid = 1'b0;
    logic [4:0] port_status = 5'h10, exp_ack_tag = 5'h00;
    lcs_sym_t usr_sym = '0;
    logic rx_valid, flush_req, flush_done, tx_valid, tx_ready, pkt_accept, pkt_abort, restart_err, dev_reset;
    logic mcast_event, eop_seen, crc_err, usr_ready, usr_reject, rej;
    lcs_sym_t rx_sym, tx_sym, ex, u;
    lcs_sym_t exp_q [$];
    logic [31:0] rng = 32'h0000001B;
    int n_fail = 0;
    int comparisons = 0;
    int n0;
    int early;

    lcs_ctrl_sym i_lcs_ctrl_sym
    (
        .clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_sym(rx_sym), .rx_pkt_data(rx_pkt_data),
        .retry_req(retry_req), .port_err(port_err), .port_status(port_status), .exp_ack_tag(exp_ack_tag),
        .pkt_accept(pkt_accept), .pkt_abort(pkt_abort), .restart_err(restart_err), .dev_reset(dev_reset),
        .mcast_event(mcast_event), .eop_seen(eop_seen), .crc_err(crc_err), .flush_req(flush_req),
        .flush_done(flush_done), .usr_valid(usr_valid), .usr_sym(usr_sym), .usr_ready(usr_ready),
        .usr_reject(usr_reject), .tx_valid(tx_valid), .tx_sym(tx_sym), .tx_ready(tx_ready)
    );
    lcs_peer_model i_lcs_peer_model
    (
        .clock(clock), .rx_valid(rx_valid), .rx_sym(rx_sym), .flush_req(flush_req), .flush_done(flush_done),
        .tx_valid(tx_valid), .tx_sym(tx_sym), .tx_ready(tx_ready)
    );

    // Clock of 4 ns
    always #2 clock = ~clock;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic lcs_sym_t sym(logic [2:0] st1, logic [2:0] cmd);
        logic [31:0] r;
        r = rnd();
        return {ST0_STATUS, r[9:0], st1, cmd, 5'h00};
    endfunction

    task automatic check(string what, logic [23:0] exp, logic [23:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One received symbol and the pulses it leaves
    task automatic rx(lcs_sym_t s, logic [4:0] flip, logic [5:0] exp);
        i_lcs_peer_model.send(s, flip);
        check("rx pulses", 24'(exp), 24'({pkt_abort, restart_err, dev_reset, mcast_event, eop_seen, crc_err}));
    endtask

    // Held until an edge samples usr_ready high
    task automatic usr_send(lcs_sym_t s);
        usr_valid = 1'b1;
        usr_sym = s;
        for (int i = 0; i < 50 && usr_ready !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        check("reset state", 24'h9, 24'({pkt_accept, flush_req, tx_valid, usr_ready}));
        foreach (ST1S[i])
            rx(sym(ST1S[i], CMD_NONE), 5'h00, EXPS[i]);
        for (int c = 0; c < 8; c++)
            if (c != 4)
                rx(sym(ST1_LREQ, 3'(c)), 5'h00, 6'h20);
        for (int i = 0; i < 16; i++)
            rx(lcs_sym_t'(24'(rnd())), 5'(rnd()) | 5'h01, 6'h01);
        // Retry stop survives other and bad symbols
        retry_req = 1'b1;
        rx(sym(ST1_EOP, CMD_NONE), 5'h00, 6'h02);
        retry_req = 1'b0;
        rx(sym(ST1_RETRY, CMD_NONE), 5'h04, 6'h01);
        check("retry stop", 24'h0, 24'(pkt_accept));
        rx(sym(ST1_RETRY, CMD_NONE), 5'h00, 6'h20);
        check("restart", 24'h1, 24'(pkt_accept));
        // Lockout count broken by packet data and an end-of-packet
        retry_req = 1'b1;
        n0 = i_lcs_peer_model.got.size();
        for (int i = 0; i < 6; i++)
        begin
            rx(sym(ST1_LREQ, CMD_RST_DEV), 5'h00, 6'h20);
            retry_req = 1'b0;
            rx_pkt_data = i == 2;
            rx(sym(i == 5 ? ST1_EOP : ST1_NOP, CMD_NONE), 5'h00, i == 5 ? 6'h02 : 6'h00);
            rx_pkt_data = 1'b0;
        end
        for (int i = 0; i < 4; i++)
        begin
            rx(lcs_sym_t'(24'(rnd())), 5'h10, 6'h01);
            rx(sym(ST1_NOP, CMD_NONE), 5'h00, 6'h00);
            rx(sym(ST1_LREQ, CMD_RST_DEV), 5'h00, i == 3 ? 6'h28 : 6'h20);
        end
        i_lcs_peer_model.idle();
        repeat (8) @(posedge clock);
        #1;
        check("reset reply", 24'(n0), 24'(i_lcs_peer_model.got.size()));
        check("power-on state", 24'h9, 24'({pkt_accept, flush_req, tx_valid, usr_ready}));
        // Input-status with and without error; inputs move after capture
        for (int e = 0; e < 2; e++)
        begin
            port_err = e == 0;
            port_status = e ? PST_OK : 5'(rnd());
            exp_ack_tag = 5'(rnd());
            ex = i_lcs_peer_model.seal({ST0_LRESP, exp_ack_tag, port_status, ST1_NOP, CMD_NONE, 5'h00});
            n0 = i_lcs_peer_model.got.size();
            early = 0;
            rx(sym(ST1_LREQ, CMD_IN_STAT), 5'h00, e ? 6'h20 : 6'h30);
            i_lcs_peer_model.idle();
            check("flush request", 24'h1, 24'(flush_req));
            port_status = ~port_status;
            exp_ack_tag = ~exp_ack_tag;
            for (int i = 0; i < 40 && i_lcs_peer_model.got.size() == n0; i++)
            begin
                @(posedge clock);
                #1;
                early += tx_valid & flush_req;
            end
            check("flush first", 24'h0, 24'(early));
            check("link response", 24'(ex), 24'(i_lcs_peer_model.got[n0]));
        end
        port_err = 1'b0;
        // User symbols: every link-request command, then random ones
        n0 = i_lcs_peer_model.got.size();
        for (int i = 0; i < 32; i++)
        begin
            u = lcs_sym_t'(24'(rnd()));
            if (i < 8)
                u = {u[23:11], ST1_LREQ, 3'(i), u.crc};
            rej = u.secondary_symbol_type == ST1_LREQ && !(u.cmd inside {CMD_RST_DEV, CMD_IN_STAT});
            usr_send(u);
            check("user reject", 24'(rej), 24'(usr_reject));
            if (!rej)
                exp_q.push_back(i_lcs_peer_model.seal(u));
        end
        usr_valid = 1'b0;
        for (int i = 0; i < 300 && i_lcs_peer_model.got.size() < n0 + exp_q.size(); i++)
            @(posedge clock);
        foreach (exp_q[i])
            check("sealed symbol", 24'(exp_q[i]), 24'(i_lcs_peer_model.got[n0 + i]));
        print_verdict();
    end

    // Watchdog far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        print_verdict();
    end
endmodule

// ---- sim/lcs_peer_model.sv ----
/*
 Peer port model: sends sealed control symbols, sinks outgoing ones, answers flush requests.
 Assumes the bench calls send and idle just after a rising clock edge.
*/
`timescale 1ns/100ps
module lcs_peer_model
(
    input wire logic clock,
    output logic rx_valid,
    output lcs_pkg::lcs_sym_t rx_sym,
    input wire logic flush_req,
    output logic flush_done,
    input wire logic tx_valid,
    input wire lcs_pkg::lcs_sym_t tx_sym,
    output logic tx_ready
);
    import lcs_pkg::*;
    // ==========================================================
    // Sealing and sending
    localparam logic [18:0] MSK [5] = '{19'h5943B, 19'h6BC4D, 19'h5789A, 19'h7650E, 19'h6CA1D};
    lcs_sym_t got [$];
    logic [7:0] cyc = 8'h00;
    logic [1:0] fcnt = 2'h0;

    // Check bits with preset and trailing zero folded in
    function automatic lcs_sym_t seal(lcs_sym_t s);
        logic [18:0] d;
        for (int i = 0; i < 19; i++)
            d[i] = s[23-i];
        for (int k = 0; k < 5; k++)
            s.crc[4-k] = ^(d & MSK[k]) ^ (k inside {1, 2, 3});
        return s;
    endfunction

    // One symbol per call; flipped check bits make it bad
    task automatic send(lcs_sym_t s, logic [4:0] flip);
        rx_valid = 1'b1;
        rx_sym = seal(s) ^ 24'(flip);
        @(posedge clock);
        #1;
    endtask

    // Released bus shows the inverse, never a stale symbol
    task automatic idle();
        rx_valid = 1'b0;
        rx_sym = ~rx_sym;
    endtask

    // Quiet link at time zero
    initial
    begin
        rx_valid = 1'b0;
        rx_sym = '0;
        tx_ready = 1'b0;
        flush_done = 1'b0;
    end

    // Sink stalls often; flush ends a few cycles after the request
    always @(posedge clock)
    begin
        cyc <= cyc + 8'h01;
        tx_ready <= cyc[1:0] == 2'h0 || cyc[6];
        flush_done <= flush_req && !flush_done && fcnt == 2'h2;
        fcnt <= flush_req && !flush_done ? fcnt + 2'h1 : 2'h0;
        if (tx_valid && tx_ready)
            got.push_back(tx_sym);
    end
endmodule
